/* verilog/rtc_irq_pkg.sv */
// constants and types for the interrupt pin controller
package rtc_irq_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [3:0] FLAGS_OFS  = 4'h0;
	localparam logic [3:0] INTCTL_OFS = 4'h6;

	////////////////////////////////////////////////////////////////////////////////
	// interrupt_control fields
	localparam int WDOG_IRQ_EN_BIT    = 7;
	localparam int ALARM_IRQ_EN_BIT   = 6;
	localparam int PWRFAIL_IRQ_EN_BIT = 5;
	localparam int SQWAVE_EN_BIT      = 4;
	localparam int POL_HIGH_BIT       = 3;
	localparam int PULSE_MODE_BIT     = 2;
	localparam int SQFREQ_SEL_HI_BIT  = 1;
	localparam int SQFREQ_SEL_LO_BIT  = 0;
	localparam logic [7:0] INTCTL_RST = 8'h08;

	////////////////////////////////////////////////////////////////////////////////
	// event_flags fields
	localparam int WDOG_FLAG_BIT  = 7;
	localparam int ALARM_FLAG_BIT = 6;
	localparam int PFAIL_FLAG_BIT = 5;
	localparam int OSC_FAIL_BIT   = 4;
	localparam int BACKUP_FAIL_BIT = 3;
	localparam int CAL_BIT        = 2;
	localparam int WRITE_EN_BIT   = 1;
	localparam int READ_LOCK_BIT  = 0;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLOCK_HZ         = 125000000;
	localparam int PULSE_TIME_MS    = 200;
	localparam int PULSE_CYCLES_DEF = PULSE_TIME_MS * (CLOCK_HZ / 1000);
	localparam int OSC_HZ           = 32768;
	localparam int CAL_HZ           = 512;
	localparam int SQ_DIV_W         = $clog2(OSC_HZ);
	localparam int SQ_BIT_1HZ       = $clog2(OSC_HZ / 1) - 1;
	localparam int SQ_BIT_512HZ     = $clog2(OSC_HZ / 512) - 1;
	localparam int SQ_BIT_4096HZ    = $clog2(OSC_HZ / 4096) - 1;
	localparam int CAL_BIT_IDX      = $clog2(OSC_HZ / CAL_HZ) - 1;

	////////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0]
	{
		SQ_1HZ    = 2'b00,
		SQ_512HZ  = 2'b01,
		SQ_4096HZ = 2'b10,
		SQ_OSC    = 2'b11
	} sqfreq_t;

	typedef enum logic
	{
		PULSE_IDLE = 1'b0,
		PULSE_ON   = 1'b1
	} pulse_state_t;

endpackage

/* verilog/sqwave_gen.sv */
// square wave and calibration wave generator from the crystal time base
`timescale 1ns/1ps
`default_nettype none
module sqwave_gen
	import rtc_irq_pkg::*;
(
	input  wire logic    clock,
	input  wire logic    sys_rst,
	input  wire logic    osc_in,
	input  wire sqfreq_t freq_sel,
	output logic         sq_wave,
	output logic         cal_wave
);

	logic                osc_meta_ff;
	logic                osc_sync_ff;
	logic                osc_prev_ff;
	logic [SQ_DIV_W-1:0] div_ff;
	logic [SQ_DIV_W-1:0] nxt_div;
	logic                sq_ff;
	logic                nxt_sq;
	logic                cal_ff;
	logic                nxt_cal;

	////////////////////////////////////////////////////////////////////////////////
	// divider chain on crystal rising edges
	always_comb
	begin
		nxt_div = div_ff;
		if (osc_sync_ff && !osc_prev_ff)
			nxt_div = div_ff + 1'b1;
		case (freq_sel) // RL11
			SQ_1HZ:    nxt_sq = div_ff[SQ_BIT_1HZ];
			SQ_512HZ:  nxt_sq = div_ff[SQ_BIT_512HZ];
			SQ_4096HZ: nxt_sq = div_ff[SQ_BIT_4096HZ];
			SQ_OSC:    nxt_sq = osc_sync_ff;
			default:   nxt_sq = 1'b0;
		endcase
		nxt_cal = div_ff[CAL_BIT_IDX]; // RL15
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			osc_meta_ff <= 1'b0;
			osc_sync_ff <= 1'b0;
			osc_prev_ff <= 1'b0;
			div_ff      <= '0;
			sq_ff       <= 1'b0;
			cal_ff      <= 1'b0;
		end
		else
		begin
			osc_meta_ff <= osc_in;
			osc_sync_ff <= osc_meta_ff;
			osc_prev_ff <= osc_sync_ff;
			div_ff      <= nxt_div;
			sq_ff       <= nxt_sq;
			cal_ff      <= nxt_cal;
		end
	end

	assign sq_wave  = sq_ff;
	assign cal_wave = cal_ff;

endmodule
`default_nettype wire

/* verilog/pulse_timer.sv */
// fixed width interrupt pulse timer with early cut
`timescale 1ns/1ps
`default_nettype none
module pulse_timer
	import rtc_irq_pkg::*;
#(
	parameter int CYCLES = PULSE_CYCLES_DEF
)
(
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic start,
	input  wire logic stop,
	output logic      active
);

	localparam int CW = $clog2(CYCLES + 1);

	generate
		if (CYCLES < 1)
		begin : g_bad_cycles
			$error("pulse_timer: CYCLES must be at least 1");
		end
	endgenerate

	pulse_state_t  state_ff;
	pulse_state_t  nxt_state;
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;

	////////////////////////////////////////////////////////////////////////////////
	// start wins over stop so an event is never lost
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			PULSE_IDLE:
				if (start)
				begin
					nxt_state = PULSE_ON;
					nxt_cnt   = '0;
				end
			PULSE_ON:
				if (start)
					nxt_cnt = '0;
				else if (stop) // RL14
					nxt_state = PULSE_IDLE;
				else if (cnt_ff == CW'(CYCLES - 1)) // RL9
					nxt_state = PULSE_IDLE;
				else
					nxt_cnt = cnt_ff + 1'b1;
			default:
				nxt_state = PULSE_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_ff <= PULSE_IDLE;
			cnt_ff   <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
		end
	end

	assign active = (state_ff == PULSE_ON);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_pulse_full_width: assert property ($fell(active) |-> $past(stop) || ($past(cnt_ff) == CW'(CYCLES - 1))) // RL9
		else $error("pulse ended before its fixed width");
	a_pulse_cut_short: assert property (active && stop && !start |=> !active) // RL14
		else $error("pulse not cut by flags read");

endmodule
`default_nettype wire

/* verilog/rtc_interrupt_pin_control.sv */
// interrupt pin controller: flags, enables, level or pulse drive, square wave
// How it works
// (RL1) watchdog timeout sets its flag; drives the pin only when its enable is set.
// (RL2) alarm match sets its flag; drives the pin only when its enable is set.
// (RL3) power fail sets its flag; drives the pin only when its enable is set.
// (RL4) square wave enable puts the selected square wave on the pin.
// (RL5) square wave enable is nonvolatile, restored at recall, factory default zero.
// (RL6) square wave overrides interrupts; calibration overrides square wave.
// (RL7) polarity one: active high push-pull; zero: active low open drain.
// (RL8) pin never driven high while running from backup.
// (RL9) pulse mode: event drives a fixed pulse of about 200 ms.
// (RL10) level mode: pin held active until flags register is read.
// (RL11) frequency select: 00 1 Hz, 01 512 Hz, 10 4096 Hz, 11 32768 Hz.
// (RL12) both frequency select bits are nonvolatile and restored at recall.
// (RL13) any flags read clears all flags and releases a level interrupt; here a flag whose event comes in the read cycle stays set.
// (RL14) flags read during a pulse ends the pulse at once.
// (RL15) calibration gives 512 Hz; nothing active leaves the pin high impedance.
// (RL16) three interrupt capable flags: watchdog, alarm, power fail.
// (RL17) flags register comes up zero, oscillator fail bit excepted; the backup fail bit also follows its input.
// (RL18) a host using the pin as reset does not read flags during reset.
// (RL19) interrupt only when a flag is set and its enable is one.
// (RL20) no interrupts while running from backup power.
// (RL21) square wave suppressed while running from backup power.
`timescale 1ns/1ps
`default_nettype none
module rtc_interrupt_pin_control
	import rtc_irq_pkg::*;
#(
	parameter int PULSE_CYCLES = PULSE_CYCLES_DEF
)
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic [3:0] reg_addr,
	input  wire logic       reg_wr_en,
	input  wire logic       reg_rd_en,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       wdog_timeout,
	input  wire logic       alarm_match,
	input  wire logic       power_fail,
	input  wire logic       osc_fail_flag,
	input  wire logic       backup_fail,
	input  wire logic       on_backup,
	input  wire logic       osc_in,
	input  wire logic       nv_recall,
	input  wire logic [2:0] nv_recall_data,
	output logic      [2:0] nv_store_data,
	output logic            int_out,
	output logic            int_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic       wdog_irq_en_ff;
	logic       alarm_irq_en_ff;
	logic       pwrfail_irq_en_ff;
	logic       sqwave_en_ff;
	logic       pol_high_ff;
	logic       pulse_mode_ff;
	logic       sqfreq_sel_hi_ff;
	logic       sqfreq_sel_lo_ff;
	logic       nxt_wdog_irq_en;
	logic       nxt_alarm_irq_en;
	logic       nxt_pwrfail_irq_en;
	logic       nxt_sqwave_en;
	logic       nxt_pol_high;
	logic       nxt_pulse_mode;
	logic       nxt_sqfreq_sel_hi;
	logic       nxt_sqfreq_sel_lo;
	logic       wdog_timeout_flag_ff;
	logic       alarm_match_flag_ff;
	logic       power_fail_flag_ff;
	logic       cal_ff;
	logic       write_en_ff;
	logic       read_lock_ff;
	logic       nxt_wdog_timeout_flag;
	logic       nxt_alarm_match_flag;
	logic       nxt_power_fail_flag;
	logic       nxt_cal;
	logic       nxt_write_en;
	logic       nxt_read_lock;
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;
	logic       backup_meta_ff;
	logic       backup_sync_ff;
	logic       int_out_ff;
	logic       int_oe_ff;
	logic       nxt_int_out;
	logic       nxt_int_oe;
	logic       wr_intctl;
	logic       wr_flags;
	logic       rd_flags;
	logic       any_en;
	logic       level_req;
	logic       pulse_start;
	logic       pulse_active;
	logic       irq_active;
	logic       sq_wave;
	logic       cal_wave;
	logic [7:0] intctl_val;
	logic [7:0] flags_val;

	assign wr_intctl = reg_wr_en && (reg_addr == INTCTL_OFS);
	assign wr_flags  = reg_wr_en && (reg_addr == FLAGS_OFS);
	assign rd_flags  = reg_rd_en && (reg_addr == FLAGS_OFS);

	////////////////////////////////////////////////////////////////////////////////
	// backup indication comes from the analog monitor: synchronise
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			backup_meta_ff <= 1'b0;
			backup_sync_ff <= 1'b0;
		end
		else
		begin
			backup_meta_ff <= on_backup;
			backup_sync_ff <= backup_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt_control register
	always_comb
	begin
		nxt_wdog_irq_en    = wdog_irq_en_ff;
		nxt_alarm_irq_en   = alarm_irq_en_ff;
		nxt_pwrfail_irq_en = pwrfail_irq_en_ff;
		nxt_sqwave_en      = sqwave_en_ff;
		nxt_pol_high       = pol_high_ff;
		nxt_pulse_mode     = pulse_mode_ff;
		nxt_sqfreq_sel_hi  = sqfreq_sel_hi_ff;
		nxt_sqfreq_sel_lo  = sqfreq_sel_lo_ff;
		if (nv_recall)
		begin
			nxt_sqwave_en     = nv_recall_data[2]; // RL5
			nxt_sqfreq_sel_hi = nv_recall_data[1]; // RL12
			nxt_sqfreq_sel_lo = nv_recall_data[0]; // RL12
		end
		else if (wr_intctl)
		begin
			nxt_wdog_irq_en    = reg_wdata[WDOG_IRQ_EN_BIT];
			nxt_alarm_irq_en   = reg_wdata[ALARM_IRQ_EN_BIT];
			nxt_pwrfail_irq_en = reg_wdata[PWRFAIL_IRQ_EN_BIT];
			nxt_sqwave_en      = reg_wdata[SQWAVE_EN_BIT];
			nxt_pol_high       = reg_wdata[POL_HIGH_BIT];
			nxt_pulse_mode     = reg_wdata[PULSE_MODE_BIT];
			nxt_sqfreq_sel_hi  = reg_wdata[SQFREQ_SEL_HI_BIT];
			nxt_sqfreq_sel_lo  = reg_wdata[SQFREQ_SEL_LO_BIT];
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			wdog_irq_en_ff    <= INTCTL_RST[WDOG_IRQ_EN_BIT];
			alarm_irq_en_ff   <= INTCTL_RST[ALARM_IRQ_EN_BIT];
			pwrfail_irq_en_ff <= INTCTL_RST[PWRFAIL_IRQ_EN_BIT];
			sqwave_en_ff      <= INTCTL_RST[SQWAVE_EN_BIT]; // RL5
			pol_high_ff       <= INTCTL_RST[POL_HIGH_BIT];
			pulse_mode_ff     <= INTCTL_RST[PULSE_MODE_BIT];
			sqfreq_sel_hi_ff  <= INTCTL_RST[SQFREQ_SEL_HI_BIT];
			sqfreq_sel_lo_ff  <= INTCTL_RST[SQFREQ_SEL_LO_BIT];
		end
		else
		begin
			wdog_irq_en_ff    <= nxt_wdog_irq_en;
			alarm_irq_en_ff   <= nxt_alarm_irq_en;
			pwrfail_irq_en_ff <= nxt_pwrfail_irq_en;
			sqwave_en_ff      <= nxt_sqwave_en;
			pol_high_ff       <= nxt_pol_high;
			pulse_mode_ff     <= nxt_pulse_mode;
			sqfreq_sel_hi_ff  <= nxt_sqfreq_sel_hi;
			sqfreq_sel_lo_ff  <= nxt_sqfreq_sel_lo;
		end
	end

	assign nv_store_data = {sqwave_en_ff, sqfreq_sel_hi_ff, sqfreq_sel_lo_ff};

	////////////////////////////////////////////////////////////////////////////////
	// event_flags register: an event in the read cycle survives the clear
	always_comb
	begin
		nxt_wdog_timeout_flag = (wdog_timeout_flag_ff && !rd_flags) || wdog_timeout; // RL1 RL13 RL16
		nxt_alarm_match_flag  = (alarm_match_flag_ff && !rd_flags) || alarm_match; // RL2 RL13 RL16
		nxt_power_fail_flag   = (power_fail_flag_ff && !rd_flags) || power_fail; // RL3 RL13 RL16
		nxt_cal               = cal_ff;
		nxt_write_en          = write_en_ff;
		nxt_read_lock         = read_lock_ff;
		if (wr_flags)
		begin
			if (write_en_ff)
				nxt_cal = reg_wdata[CAL_BIT];
			nxt_write_en  = reg_wdata[WRITE_EN_BIT];
			nxt_read_lock = reg_wdata[READ_LOCK_BIT];
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			wdog_timeout_flag_ff <= FLAGS_RST[WDOG_FLAG_BIT]; // RL17
			alarm_match_flag_ff  <= FLAGS_RST[ALARM_FLAG_BIT]; // RL17
			power_fail_flag_ff   <= FLAGS_RST[PFAIL_FLAG_BIT]; // RL17
			cal_ff               <= FLAGS_RST[CAL_BIT]; // RL17
			write_en_ff          <= FLAGS_RST[WRITE_EN_BIT];
			read_lock_ff         <= FLAGS_RST[READ_LOCK_BIT];
		end
		else
		begin
			wdog_timeout_flag_ff <= nxt_wdog_timeout_flag;
			alarm_match_flag_ff  <= nxt_alarm_match_flag;
			power_fail_flag_ff   <= nxt_power_fail_flag;
			cal_ff               <= nxt_cal;
			write_en_ff          <= nxt_write_en;
			read_lock_ff         <= nxt_read_lock;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data, captured on the read strobe
	always_comb
	begin
		intctl_val = {wdog_irq_en_ff, alarm_irq_en_ff, pwrfail_irq_en_ff, sqwave_en_ff,
			pol_high_ff, pulse_mode_ff, sqfreq_sel_hi_ff, sqfreq_sel_lo_ff};
		flags_val  = {wdog_timeout_flag_ff, alarm_match_flag_ff, power_fail_flag_ff,
			osc_fail_flag, backup_fail, cal_ff, write_en_ff, read_lock_ff};
		nxt_rdata  = rdata_ff;
		if (reg_rd_en)
		begin
			case (reg_addr)
				FLAGS_OFS:  nxt_rdata = flags_val;
				INTCTL_OFS: nxt_rdata = intctl_val;
				default:    nxt_rdata = UNMAPPED_READ;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	assign reg_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////////////
	// interrupt sources
	assign any_en      = wdog_irq_en_ff || alarm_irq_en_ff || pwrfail_irq_en_ff;
	assign level_req   = (wdog_timeout_flag_ff && wdog_irq_en_ff) || // RL19
		(alarm_match_flag_ff && alarm_irq_en_ff) ||
		(power_fail_flag_ff && pwrfail_irq_en_ff);
	assign pulse_start = pulse_mode_ff && !backup_sync_ff && // RL20
		((wdog_timeout && wdog_irq_en_ff) || (alarm_match && alarm_irq_en_ff) ||
		(power_fail && pwrfail_irq_en_ff));
	assign irq_active  = !backup_sync_ff && (pulse_mode_ff ? pulse_active : level_req); // RL9 RL10 RL20

	pulse_timer #(
		.CYCLES (PULSE_CYCLES)
	) u_pulse (
		.clock   (clock),
		.sys_rst (sys_rst),
		.start   (pulse_start),
		.stop    (rd_flags),
		.active  (pulse_active)
	);

	sqwave_gen u_sqwave (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.osc_in   (osc_in),
		.freq_sel (sqfreq_t'({sqfreq_sel_hi_ff, sqfreq_sel_lo_ff})),
		.sq_wave  (sq_wave),
		.cal_wave (cal_wave)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pin driver: calibration, then square wave, then interrupt
	always_comb
	begin
		logic lvl;
		logic drive;
		lvl   = 1'b0;
		drive = 1'b1;
		if (backup_sync_ff) // RL8 RL21
			drive = 1'b0;
		else if (cal_ff) // RL6 RL15
			lvl = cal_wave;
		else if (sqwave_en_ff) // RL4 RL6
			lvl = sq_wave;
		else if (any_en)
			lvl = pol_high_ff ? irq_active : !irq_active; // RL7
		else // RL15
			drive = 1'b0;
		if (!drive)
		begin
			nxt_int_out = 1'b0;
			nxt_int_oe  = 1'b0;
		end
		else if (pol_high_ff) // RL7
		begin
			nxt_int_out = lvl;
			nxt_int_oe  = 1'b1;
		end
		else
		begin
			nxt_int_out = 1'b0;
			nxt_int_oe  = !lvl;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			int_out_ff <= 1'b0;
			int_oe_ff  <= 1'b0;
		end
		else
		begin
			int_out_ff <= nxt_int_out;
			int_oe_ff  <= nxt_int_oe;
		end
	end

	assign int_out = int_out_ff;
	assign int_oe  = int_oe_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	sequence s_level_irq_idle;
		!pulse_mode_ff && pol_high_ff && !cal_ff && !sqwave_en_ff && !backup_sync_ff && any_en;
	endsequence
	sequence s_clean_read;
		rd_flags && !wdog_timeout && !alarm_match && !power_fail && !wr_intctl && !nv_recall;
	endsequence

	a_wdog_flag_set: assert property (wdog_timeout |=> wdog_timeout_flag_ff) // RL1
		else $error("watchdog flag not set");
	a_alarm_flag_set: assert property (alarm_match |=> alarm_match_flag_ff) // RL2
		else $error("alarm flag not set");
	a_pfail_flag_set: assert property (power_fail |=> power_fail_flag_ff) // RL3
		else $error("power fail flag not set");
	a_read_clears_flags: assert property (s_clean_read |=> !wdog_timeout_flag_ff && !alarm_match_flag_ff
		&& !power_fail_flag_ff) // RL13
		else $error("flags not cleared by read");
	a_level_release: assert property (s_level_irq_idle and s_clean_read |=> ##1 !int_out_ff) // RL10
		else $error("level interrupt not released after read");
	a_no_high_backup: assert property (backup_sync_ff |=> !(int_oe_ff && int_out_ff)) // RL8
		else $error("pin driven high on backup");
	a_opendrain_low: assert property (!pol_high_ff && !nv_recall && !wr_intctl |=> !int_out_ff) // RL7
		else $error("open drain pin drove high");
	a_cal_priority: assert property (cal_ff && pol_high_ff && !backup_sync_ff
		|=> int_oe_ff && int_out_ff == $past(cal_wave)) // RL6
		else $error("calibration wave not on pin");
	a_hiz_idle: assert property (!cal_ff && !sqwave_en_ff && !any_en |=> !int_oe_ff) // RL15
		else $error("idle pin not high impedance");
	a_nv_recall: assert property (nv_recall |=> nv_store_data == $past(nv_recall_data)) // RL5
		else $error("nonvolatile bits not restored");

endmodule
`default_nettype wire

/* tb/host_pin_monitor.sv */
// host side view of the interrupt pin with its board pull-up
`timescale 1ns/1ps
`default_nettype none
module host_pin_monitor
(
	input  wire logic        clock,
	input  wire logic        int_out,
	input  wire logic        int_oe,
	output logic             pin,
	output logic      [31:0] rise_count,
	output logic      [31:0] period
);
	logic        pin_d;
	logic [31:0] run;

	////////////////////////////////////////////////////////////////////////////////
	// released pin floats up; passive, never reads flags while pin is low
	assign pin = int_oe ? int_out : 1'b1;

	initial
	begin
		pin_d = 1'b1;
		run = 32'h0;
		rise_count = 32'h0;
		period = 32'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// cycles between rising edges of the pin
	always @(posedge clock)
	begin
		pin_d <= pin;
		if (pin && !pin_d)
		begin
			rise_count <= rise_count + 32'h1;
			period <= run;
			run <= 32'h1;
		end
		else
			run <= run + 32'h1;
	end
endmodule
`default_nettype wire

/* tb/rtc_interrupt_pin_control_tb_top.sv */
// self-checking bench of the interrupt pin controller
`timescale 1ns/1ps
`default_nettype none
module rtc_interrupt_pin_control_tb_top;
	import rtc_irq_pkg::*;
	localparam int P = 20;
	logic        clock, sys_rst, reg_wr_en, reg_rd_en, wdog_timeout, alarm_match, power_fail;
	logic        osc_fail_flag, backup_fail, on_backup, osc_in, nv_recall, int_out, int_oe, pin;
	logic [3:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	logic [2:0]  nv_recall_data, nv_store_data;
	logic [31:0] rise_count, period;
	int          err_count, n_checks;

	rtc_interrupt_pin_control #(.PULSE_CYCLES(P)) dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.wdog_timeout(wdog_timeout), .alarm_match(alarm_match), .power_fail(power_fail),
		.osc_fail_flag(osc_fail_flag), .backup_fail(backup_fail), .on_backup(on_backup), .osc_in(osc_in),
		.nv_recall(nv_recall), .nv_recall_data(nv_recall_data), .nv_store_data(nv_store_data),
		.int_out(int_out), .int_oe(int_oe));
	host_pin_monitor host (.clock(clock), .int_out(int_out), .int_oe(int_oe), .pin(pin),
		.rise_count(rise_count), .period(period));

	always #4 clock = ~clock;
	// crystal stand-in: period of 8 clock cycles
	always
	begin
		repeat (4) @(negedge clock);
		osc_in = ~osc_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
		chk32(name, {24'h0, exp}, {24'h0, got});
	endtask
	task automatic chk1(input string name, input logic exp, input logic got);
		chk32(name, {31'h0, exp}, {31'h0, got});
	endtask
	task automatic cycles(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge clock);
		reg_wr_en = 1'b0;
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		@(negedge clock);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clock);
		reg_rd_en = 1'b0;
		chk8("reg_rdata", exp, reg_rdata);
	endtask
	task automatic fire(input int src);
		@(negedge clock);
		wdog_timeout = (src == 0);
		alarm_match = (src == 1);
		power_fail = (src == 2);
		@(negedge clock);
		{wdog_timeout, alarm_match, power_fail} = 3'b000;
	endtask
	task automatic wait_rises(input logic [31:0] n);
		logic [31:0] c0;
		c0 = rise_count;
		for (int k = 0; k < 5000 && rise_count < c0 + n; k++)
			cycles(1);
		// a wave that never shows up counts as a mismatch
		if (rise_count < c0 + n)
			chk32("rise_count", c0 + n, rise_count);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk1("int_oe", 1'b0, int_oe);
		chk8("nv_store_data", 8'h00, {5'h0, nv_store_data});
		rdchk(INTCTL_OFS, INTCTL_RST);
		rdchk(4'h3, UNMAPPED_READ);
		osc_fail_flag = 1'b1;
		backup_fail = 1'b1;
		rdchk(FLAGS_OFS, 8'h18);
		osc_fail_flag = 1'b0;
		backup_fail = 1'b0;
		rdchk(FLAGS_OFS, FLAGS_RST);
	endtask
	task automatic t_level();
		for (int i = 0; i < 3; i++)
		begin
			wr(INTCTL_OFS, 8'h08 | (8'h80 >> i));
			fire(i);
			// flag lands on the event edge, pin one edge later
			chk1("int_out", 1'b0, int_out);
			cycles(1);
			chk1("int_out", 1'b1, int_out);
			chk1("int_oe", 1'b1, int_oe);
			cycles(5);
			chk1("int_out", 1'b1, int_out);
			rdchk(FLAGS_OFS, 8'h80 >> i);
			cycles(2);
			chk1("int_out", 1'b0, int_out);
		end
		wr(INTCTL_OFS, 8'h48);
		fire(0);
		cycles(3);
		chk1("int_out", 1'b0, int_out);
		rdchk(FLAGS_OFS, 8'h80);
		rdchk(FLAGS_OFS, 8'h00);
	endtask
	task automatic t_pulse();
		int n;
		n = 0;
		wr(INTCTL_OFS, 8'h8C);
		fire(0);
		repeat (100)
		begin
			cycles(1);
			if (int_out === 1'b1)
				n++;
		end
		chk32("pulse_len", P, n);
		rdchk(FLAGS_OFS, 8'h80);
		fire(0);
		cycles(4);
		chk1("int_out", 1'b1, int_out);
		rdchk(FLAGS_OFS, 8'h80);
		cycles(2);
		chk1("int_out", 1'b0, int_out);
		cycles(P);
		chk1("int_out", 1'b0, int_out);
	endtask
	task automatic t_open_drain();
		wr(INTCTL_OFS, 8'h80);
		cycles(1);
		chk1("int_oe", 1'b0, int_oe);
		fire(0);
		cycles(2);
		chk1("pin", 1'b0, pin);
		rdchk(FLAGS_OFS, 8'h80);
		cycles(2);
		chk1("pin", 1'b1, pin);
	endtask
	task automatic t_backup();
		// pulse mode: a pulse started on backup would still run after release
		wr(INTCTL_OFS, 8'h8C);
		on_backup = 1'b1;
		cycles(3);
		fire(0);
		cycles(3);
		chk1("int_oe", 1'b0, int_oe);
		on_backup = 1'b0;
		cycles(4);
		chk1("int_out", 1'b0, int_out);
		rdchk(FLAGS_OFS, 8'h80);
	endtask
	task automatic t_sqwave();
		logic [31:0] exp_p [4];
		logic [31:0] c;
		exp_p = '{32'h0, 32'h200, 32'h40, 32'h8};
		wr(INTCTL_OFS, 8'h88);
		fire(0);
		for (int s = 1; s < 4; s++)
		begin
			wr(INTCTL_OFS, 8'h98 | 8'(s));
			wait_rises(3);
			chk32("period", exp_p[s], period);
		end
		wr(INTCTL_OFS, 8'h98);
		cycles(4);
		c = rise_count;
		cycles(3000);
		chk32("rises_1hz", c, rise_count);
		wr(INTCTL_OFS, 8'h9B);
		on_backup = 1'b1;
		cycles(4);
		c = rise_count;
		cycles(40);
		chk32("rises_backup", c, rise_count);
		chk1("int_oe", 1'b0, int_oe);
		on_backup = 1'b0;
		wr(FLAGS_OFS, 8'h02);
		wr(FLAGS_OFS, 8'h06);
		wait_rises(3);
		chk32("period_cal", 32'h200, period);
		rdchk(FLAGS_OFS, 8'h86);
		wr(FLAGS_OFS, 8'h02);
		wr(FLAGS_OFS, 8'h00);
		wr(INTCTL_OFS, 8'h08);
	endtask
	task automatic t_nv();
		nv_recall_data = 3'b101;
		nv_recall = 1'b1;
		cycles(1);
		nv_recall = 1'b0;
		cycles(1);
		chk8("nv_store_data", 8'h05, {5'h0, nv_store_data});
		rdchk(INTCTL_OFS, 8'h19);
		wr(INTCTL_OFS, 8'h0A);
		chk8("nv_store_data", 8'h02, {5'h0, nv_store_data});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		{clock, reg_wr_en, reg_rd_en, wdog_timeout, alarm_match, power_fail} = 6'h00;
		{osc_fail_flag, backup_fail, on_backup, osc_in, nv_recall} = 5'h00;
		sys_rst = 1'b1;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		nv_recall_data = 3'h0;
		err_count = 0;
		n_checks = 0;
		repeat (4) @(negedge clock);
		sys_rst = 1'b0;
		t_reset();
		t_level();
		t_pulse();
		t_open_drain();
		t_backup();
		t_sqwave();
		t_nv();
		finish_test();
	end
	initial
	begin
		#320000;
		err_count++;
		finish_test();
	end
endmodule
`default_nettype wire
